//--- exec_unit_defines.vh
`ifndef EXEC_UNIT_DEFINES_VH
`define EXEC_UNIT_DEFINES_VH

// register byte offsets
`define OFS_CTRL      6'h00
`define OFS_OPA       6'h04
`define OFS_OPB       6'h08
`define OFS_SR        6'h0C
`define OFS_RESULT    6'h10
`define OFS_FLAGS     6'h14
`define OFS_IRQ_STAT  6'h18
`define OFS_IRQ_MASK  6'h1C
`define OFS_ADDR      6'h20
`define OFS_RESULT2   6'h24

// control word fields
`define CTRL_START    31
`define CTRL_CNT_REG  18
`define CTRL_MEM      7

// status register bits
`define SR_C          0
`define SR_V          1
`define SR_Z          2
`define SR_N          3
`define SR_X          4
`define SR_S          13
`define SR_RESET      16'h2700

// operand sizes
`define SZ_BYTE       2'h0
`define SZ_WORD       2'h1

// operation codes
`define OP_AND        5'h00
`define OP_OR         5'h01
`define OP_XOR        5'h02
`define OP_NOT        5'h03
`define OP_ASL        5'h04
`define OP_ASR        5'h05
`define OP_LSL        5'h06
`define OP_LSR        5'h07
`define OP_ROL        5'h08
`define OP_ROR        5'h09
`define OP_ROTATE_LEFT_THROUGH_EXTEND       5'h0A
`define OP_ROTATE_RIGHT_THROUGH_EXTEND       5'h0B
`define OP_BIT_TEST_OP       5'h0C
`define OP_BIT_TEST_SET_OP       5'h0D
`define OP_BIT_TEST_CLEAR_OP       5'h0E
`define OP_BIT_TEST_CHANGE_OP       5'h0F
`define OP_DADD       5'h10
`define OP_DSUB       5'h11
`define OP_DNEG       5'h12
`define OP_BRANCH     5'h13
`define OP_DECBR      5'h14
`define OP_SETBYTE    5'h15
`define OP_RETURN     5'h16
`define OP_SR_LOGIC   5'h17
`define OP_SR_READ    5'h18
`define OP_PRIV_MOVE  5'h19
`define OP_EXT_RESET  5'h1A
`define OP_EXC_RETURN 5'h1B
`define OP_STOP       5'h1C
`define OP_BOUNDS     5'h1D
`define OP_TRAP       5'h1E
`define OP_CCR        5'h1F

// external reset counter load value; the pulse lasts one clock cycle less than this
`define RESET_PULSE_CYCLES 8'h7C

`endif

//--- bcd_adder.v
`timescale 1ns/1ps
`include "exec_unit_defines.vh"

module bcd_adder (
    input  wire [7:0] a_in,
    input  wire [7:0] b_in,
    input  wire       x_in,
    input  wire       sub_in,
    output wire [7:0] sum_out,
    output wire       carry_out
);
    // binary sum or difference first, then decimal correction per digit
    wire [4:0] lo_add  = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, x_in};
    wire [4:0] lo_sub  = {1'b0, a_in[3:0]} - {1'b0, b_in[3:0]} - {4'h0, x_in};
    wire [8:0] bin_add = {1'b0, a_in} + {1'b0, b_in} + {8'h00, x_in};
    wire [8:0] bin_sub = {1'b0, a_in} - {1'b0, b_in} - {8'h00, x_in};
    wire       lo_fix  = sub_in ? lo_sub[4] : (lo_add > 5'h09);
    wire [8:0] adj_add = bin_add + (lo_fix ? 9'h006 : 9'h000);
    wire [8:0] adj_sub = bin_sub - (lo_fix ? 9'h006 : 9'h000);
    // a borrow out of the byte or a sum past 99 needs the high digit fixed
    wire       hi_add  = (bin_add > 9'h099);
    wire       hi_sub  = bin_sub[8];
    wire [8:0] fin_add = adj_add + (hi_add ? 9'h060 : 9'h000);
    wire [8:0] fin_sub = adj_sub - (hi_sub ? 9'h060 : 9'h000);

    assign sum_out   = sub_in ? fin_sub[7:0] : fin_add[7:0];
    assign carry_out = sub_in ? hi_sub : hi_add;
endmodule

//--- exec_unit.v
// Local design decisions: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "exec_unit_defines.vh"
module exec_unit (
    input  wire        ref_clk_in,
    input  wire        rst_b_in,
    input  wire        ce_in,
    input  wire        wb_cyc_in,
    input  wire        wb_stb_in,
    input  wire        wb_we_in,
    input  wire [5:0]  wb_adr_in,
    input  wire [3:0]  wb_sel_in,
    input  wire [31:0] wb_dat_in,
    output wire [31:0] wb_dat_out,
    output wire        wb_ack_out,
    output wire        irq_out,
    output wire        ext_reset_out
);
    localparam ST_IDLE  = 2'b00;
    localparam ST_EXEC  = 2'b01;
    localparam ST_SHIFT = 2'b10;

    reg [31:0] ctrl_ff;
    reg [31:0] opa_ff;
    reg [31:0] opb_ff;
    reg [31:0] addr_ff;
    reg [31:0] res_ff;
    reg [31:0] res2_ff;
    reg [31:0] rd_ff;
    reg [15:0] sr_ff;
    reg [1:0]  state_ff;
    reg [5:0]  cnt_ff;
    reg [7:0]  rst_cnt_ff;
    reg [2:0]  irq_stat_ff;
    reg [2:0]  irq_mask_ff;
    reg        ack_ff;
    reg        irq_ff;
    reg        ext_rst_ff;
    reg        taken_ff;
    reg        cond_ff;
    reg        trap_ff;
    reg        priv_ff;
    reg        stop_ff;
    reg        xw_ff;
    reg        cw_ff;
    reg        vw_ff;

    assign wb_dat_out    = rd_ff;
    assign wb_ack_out    = ack_ff;
    assign irq_out       = irq_ff;
    assign ext_reset_out = ext_rst_ff;

    // decoded control fields
    wire [4:0]  op      = ctrl_ff[4:0];
    wire        mem     = ctrl_ff[`CTRL_MEM];
    wire [1:0]  sz      = mem ? `SZ_WORD : ctrl_ff[6:5];
    wire [3:0]  vnt     = ctrl_ff[17:14];
    wire [5:0]  cnt_src = ctrl_ff[`CTRL_CNT_REG] ? opb_ff[5:0] : ctrl_ff[13:8];
    wire [4:0]  condition_code_byte     = sr_ff[4:0];
    wire        sup     = sr_ff[`SR_S];

    function [31:0] size_mask;
        input [1:0] s;
        begin
            case (s)
                `SZ_BYTE: size_mask = 32'h000000FF;
                `SZ_WORD: size_mask = 32'h0000FFFF;
                default:  size_mask = 32'hFFFFFFFF;
            endcase
        end
    endfunction

    function [31:0] size_top;
        input [1:0] s;
        begin
            case (s)
                `SZ_BYTE: size_top = 32'h00000080;
                `SZ_WORD: size_top = 32'h00008000;
                default:  size_top = 32'h80000000;
            endcase
        end
    endfunction

    function cond_eval;
        input [3:0] c;
        input [4:0] f;
        reg         n_xor_v;
        begin
            n_xor_v = f[`SR_N] ^ f[`SR_V];
            case (c)
                4'h0: cond_eval = 1'b1;
                4'h1: cond_eval = 1'b0;
                4'h2: cond_eval = ~f[`SR_C] & ~f[`SR_Z];
                4'h3: cond_eval = f[`SR_C] | f[`SR_Z];
                4'h4: cond_eval = ~f[`SR_C];
                4'h5: cond_eval = f[`SR_C];
                4'h6: cond_eval = ~f[`SR_Z];
                4'h7: cond_eval = f[`SR_Z];
                4'h8: cond_eval = ~f[`SR_V];
                4'h9: cond_eval = f[`SR_V];
                4'hA: cond_eval = ~f[`SR_N];
                4'hB: cond_eval = f[`SR_N];
                4'hC: cond_eval = ~n_xor_v;
                4'hD: cond_eval = n_xor_v;
                4'hE: cond_eval = ~f[`SR_Z] & ~n_xor_v;
                default: cond_eval = f[`SR_Z] | n_xor_v;
            endcase
        end
    endfunction

    // byte lanes of a bus write, one lane per select bit
    wire [31:0] wmask;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
            assign wmask[gi*8 +: 8] = {8{wb_sel_in[gi]}};
        end
    endgenerate

    wire [31:0] msk = size_mask(sz);
    wire [31:0] top = size_top(sz);
    wire        cnd = cond_eval(vnt, condition_code_byte);

    // logic result, immediate forms use the second operand the same way
    reg [31:0] logic_val;
    always @* begin
        case (op)
            `OP_AND: logic_val = opa_ff & opb_ff;
            `OP_OR:  logic_val = opa_ff | opb_ff;
            `OP_XOR: logic_val = opa_ff ^ opb_ff;
            default: logic_val = ~opa_ff;
        endcase
    end

    // bit number wraps at 8 for byte size and at 32 for any other size, word or long
    wire [4:0]  bit_no   = (sz == `SZ_BYTE) ? {2'b00, opb_ff[2:0]} : opb_ff[4:0];
    wire [31:0] bit_sel  = 32'h00000001 << bit_no;
    wire        bit_orig = |(opa_ff & bit_sel);

    // decimal arithmetic through the shared adder
    wire [7:0] bcd_sum;
    wire       bcd_carry;
    bcd_adder u_bcd (
        .a_in      (op == `OP_DNEG ? 8'h00 : opa_ff[7:0]),
        .b_in      (op == `OP_DNEG ? opa_ff[7:0] : opb_ff[7:0]),
        .x_in      (sr_ff[`SR_X]),
        .sub_in    (op != `OP_DADD),
        .sum_out   (bcd_sum),
        .carry_out (bcd_carry)
    );

    // displacements for branches and returns
    wire [31:0] disp    = (sz == `SZ_BYTE) ? {{24{opb_ff[7]}}, opb_ff[7:0]}
                                          : {{16{opb_ff[15]}}, opb_ff[15:0]};
    wire [31:0] disp16  = {{16{opb_ff[15]}}, opb_ff[15:0]};
    wire [15:0] dec_cnt = opa_ff[15:0] - 16'h0001;
    wire        is_priv = (op >= `OP_SR_LOGIC) && (op <= `OP_STOP);

    // one-bit shift step; the loop runs one position per clock
    reg  [31:0] cur_v;
    reg         out_b;
    reg         fill_b;
    reg  [31:0] shifted;
    wire        left = ~op[0];
    wire        cur_msb = |(res_ff & top);
    always @* begin
        cur_v = res_ff;
        out_b = left ? cur_msb : res_ff[0];
        case (op)
            `OP_ASR:  fill_b = cur_msb;
            `OP_ROL:  fill_b = cur_msb;
            `OP_ROR:  fill_b = res_ff[0];
            `OP_ROTATE_LEFT_THROUGH_EXTEND: fill_b = xw_ff;
            `OP_ROTATE_RIGHT_THROUGH_EXTEND: fill_b = xw_ff;
            default:  fill_b = 1'b0;
        endcase
        if (left) begin
            shifted = (cur_v << 1) | {31'h00000000, fill_b};
        end else begin
            shifted = ((cur_v & msk) >> 1) | (fill_b ? top : 32'h00000000);
        end
        shifted = (cur_v & ~msk) | (shifted & msk);
    end
    wire new_msb  = |(shifted & top);
    wire is_rot   = (op == `OP_ROL) || (op == `OP_ROR);
    wire is_rox   = (op == `OP_ROTATE_LEFT_THROUGH_EXTEND) || (op == `OP_ROTATE_RIGHT_THROUGH_EXTEND);

    // bus decode; a request is answered once, ack drops the next cycle
    wire        wb_req = wb_cyc_in & wb_stb_in & ~ack_ff;
    wire        wr_hit = wb_req & wb_we_in;
    wire        idle   = (state_ff == ST_IDLE);
    wire        start  = wr_hit && (wb_adr_in == `OFS_CTRL) && wb_sel_in[3]
                         && wb_dat_in[`CTRL_START] && idle;
    wire [2:0]  w1c    = (wr_hit && wb_adr_in == `OFS_IRQ_STAT && wb_sel_in[0])
                         ? wb_dat_in[2:0] : 3'b000;

    reg [31:0] nxt_rd;
    always @* begin
        case (wb_adr_in)
            `OFS_CTRL:     nxt_rd = {1'b0, ctrl_ff[30:0]};
            `OFS_OPA:      nxt_rd = opa_ff;
            `OFS_OPB:      nxt_rd = opb_ff;
            `OFS_SR:       nxt_rd = {16'h0000, sr_ff};
            `OFS_RESULT:   nxt_rd = res_ff;
            `OFS_FLAGS:    nxt_rd = {25'h0000000, ext_rst_ff, ~idle, stop_ff,
                                     priv_ff, trap_ff, cond_ff, taken_ff};
            `OFS_IRQ_STAT: nxt_rd = {29'h00000000, irq_stat_ff};
            `OFS_IRQ_MASK: nxt_rd = {29'h00000000, irq_mask_ff};
            `OFS_ADDR:     nxt_rd = addr_ff;
            `OFS_RESULT2:  nxt_rd = res2_ff;
            default:       nxt_rd = 32'h00000000; // unmapped reads as zero
        endcase
    end

    // single-cycle execution of everything except shifts and rotates of any count
    reg [31:0] nxt_res;
    reg [31:0] nxt_res2;
    reg [15:0] nxt_sr;
    reg        nxt_taken;
    reg        nxt_trap;
    reg        nxt_priv;
    reg        nxt_stop;
    reg        go_shift;
    reg        go_reset;
    always @* begin
        nxt_res   = opa_ff;
        nxt_res2  = res2_ff;
        nxt_sr    = sr_ff;
        nxt_taken = 1'b0;
        nxt_trap  = 1'b0;
        nxt_priv  = 1'b0;
        nxt_stop  = 1'b0;
        go_shift  = 1'b0;
        go_reset  = 1'b0;
        if (is_priv && !sup) begin
            nxt_priv = 1'b1;
        end else begin
            case (op)
                `OP_AND, `OP_OR, `OP_XOR, `OP_NOT: begin
                    nxt_res       = (opa_ff & ~msk) | (logic_val & msk);
                    nxt_sr[`SR_N] = |(logic_val & top);
                    nxt_sr[`SR_Z] = ~|(logic_val & msk);
                    nxt_sr[`SR_V] = 1'b0;
                    nxt_sr[`SR_C] = 1'b0;
                end
                `OP_ASL, `OP_ASR, `OP_LSL, `OP_LSR,
                `OP_ROL, `OP_ROR, `OP_ROTATE_LEFT_THROUGH_EXTEND, `OP_ROTATE_RIGHT_THROUGH_EXTEND: begin
                    go_shift = 1'b1;
                end
                `OP_BIT_TEST_OP, `OP_BIT_TEST_SET_OP, `OP_BIT_TEST_CLEAR_OP, `OP_BIT_TEST_CHANGE_OP: begin
                    nxt_sr[`SR_Z] = ~bit_orig;
                    case (op)
                        `OP_BIT_TEST_SET_OP: nxt_res = opa_ff | bit_sel;
                        `OP_BIT_TEST_CLEAR_OP: nxt_res = opa_ff & ~bit_sel;
                        `OP_BIT_TEST_CHANGE_OP: nxt_res = opa_ff ^ bit_sel;
                        default:  nxt_res = opa_ff;
                    endcase
                end
                `OP_DADD, `OP_DSUB, `OP_DNEG: begin
                    nxt_res       = {opa_ff[31:8], bcd_sum};
                    nxt_sr[`SR_C] = bcd_carry;
                    nxt_sr[`SR_X] = bcd_carry;
                    if (bcd_sum != 8'h00) begin
                        nxt_sr[`SR_Z] = 1'b0; // zero only cleared, never set
                    end
                end
                `OP_BRANCH: begin
                    // never and always codes act as the unconditional forms
                    nxt_taken = cnd || (vnt[3:1] == 3'b000);
                    nxt_res   = nxt_taken ? addr_ff + disp : addr_ff;
                end
                `OP_DECBR: begin
                    nxt_res2 = addr_ff + disp16;
                    if (!cnd) begin
                        nxt_res   = {opa_ff[31:16], dec_cnt};
                        nxt_taken = (dec_cnt != 16'hFFFF);
                    end
                end
                `OP_SETBYTE: begin
                    nxt_res = {opa_ff[31:8], cnd ? 8'hFF : 8'h00};
                end
                `OP_RETURN: begin
                    nxt_taken = 1'b1;
                    case (vnt[1:0])
                        2'b01: begin
                            nxt_sr[4:0] = opb_ff[4:0];
                            nxt_res2    = addr_ff + 32'h00000006;
                        end
                        2'b10: nxt_res2 = addr_ff + 32'h00000004 + disp16;
                        default: nxt_res2 = addr_ff + 32'h00000004;
                    endcase
                end
                `OP_SR_LOGIC: begin
                    case (vnt[1:0])
                        2'b00: nxt_sr = sr_ff & opb_ff[15:0];
                        2'b01: nxt_sr = sr_ff | opb_ff[15:0];
                        2'b10: nxt_sr = sr_ff ^ opb_ff[15:0];
                        default: nxt_sr = opb_ff[15:0];
                    endcase
                end
                `OP_SR_READ: begin
                    nxt_res = {opa_ff[31:16], sr_ff};
                end
                `OP_EXT_RESET: begin
                    go_reset = 1'b1;
                end
                `OP_EXC_RETURN: begin
                    nxt_sr    = opb_ff[15:0];
                    nxt_taken = 1'b1;
                end
                `OP_STOP: begin
                    nxt_sr   = opb_ff[15:0];
                    nxt_stop = 1'b1;
                end
                `OP_BOUNDS: begin
                    if (opa_ff[15]) begin
                        nxt_sr[`SR_N] = 1'b1;
                        nxt_trap      = 1'b1;
                    end else if ($signed(opa_ff[15:0]) > $signed(opb_ff[15:0])) begin
                        nxt_sr[`SR_N] = 1'b0;
                        nxt_trap      = 1'b1;
                    end
                end
                `OP_TRAP: begin
                    nxt_trap = vnt[0] ? sr_ff[`SR_V] : 1'b1;
                end
                `OP_CCR: begin
                    case (vnt[2:0])
                        3'h0: nxt_sr[4:0] = condition_code_byte & opb_ff[4:0];
                        3'h1: nxt_sr[4:0] = condition_code_byte | opb_ff[4:0];
                        3'h2: nxt_sr[4:0] = condition_code_byte ^ opb_ff[4:0];
                        3'h3: nxt_sr[4:0] = opb_ff[4:0];
                        default: nxt_res = {opa_ff[31:8], 3'b000, condition_code_byte};
                    endcase
                end
                default: nxt_res = opa_ff; // privileged alternate_space_move pass the operand
            endcase
        end
    end

    always @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl_ff     <= 32'h00000000;
            opa_ff      <= 32'h00000000;
            opb_ff      <= 32'h00000000;
            addr_ff     <= 32'h00000000;
            res_ff      <= 32'h00000000;
            res2_ff     <= 32'h00000000;
            rd_ff       <= 32'h00000000;
            sr_ff       <= `SR_RESET;
            state_ff    <= ST_IDLE;
            cnt_ff      <= 6'h00;
            rst_cnt_ff  <= 8'h00;
            irq_stat_ff <= 3'h0;
            irq_mask_ff <= 3'h0;
            ack_ff      <= 1'b0;
            irq_ff      <= 1'b0;
            ext_rst_ff  <= 1'b0;
            taken_ff    <= 1'b0;
            cond_ff     <= 1'b0;
            trap_ff     <= 1'b0;
            priv_ff     <= 1'b0;
            stop_ff     <= 1'b0;
            xw_ff       <= 1'b0;
            cw_ff       <= 1'b0;
            vw_ff       <= 1'b0;
        end else if (ce_in) begin
            ack_ff <= wb_req;
            if (wb_req) begin
                rd_ff <= nxt_rd;
            end
            // operands and control stay frozen while an operation runs
            if (wr_hit && idle) begin
                case (wb_adr_in)
                    `OFS_CTRL: ctrl_ff <= (ctrl_ff & ~wmask) | (wb_dat_in & wmask);
                    `OFS_OPA:  opa_ff  <= (opa_ff & ~wmask) | (wb_dat_in & wmask);
                    `OFS_OPB:  opb_ff  <= (opb_ff & ~wmask) | (wb_dat_in & wmask);
                    `OFS_ADDR: addr_ff <= (addr_ff & ~wmask) | (wb_dat_in & wmask);
                    `OFS_SR:   sr_ff   <= (sr_ff & ~wmask[15:0]) | (wb_dat_in[15:0] & wmask[15:0]);
                    `OFS_IRQ_MASK: if (wb_sel_in[0]) irq_mask_ff <= wb_dat_in[2:0];
                    default: ;
                endcase
            end
            // a new event wins over a clear in the same cycle
            irq_stat_ff <= (irq_stat_ff & ~w1c)
                           | {nxt_priv & (state_ff == ST_EXEC),
                              nxt_trap & (state_ff == ST_EXEC),
                              (state_ff == ST_EXEC & ~go_shift)
                              | (state_ff == ST_SHIFT & cnt_ff == 6'h00)};
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
            // external reset line only; no internal state is touched
            if (rst_cnt_ff != 8'h00) begin
                rst_cnt_ff <= rst_cnt_ff - 8'h01;
            end
            ext_rst_ff <= (rst_cnt_ff > 8'h01);
            case (state_ff)
                ST_IDLE: begin
                    if (start) begin
                        state_ff <= ST_EXEC;
                        stop_ff  <= 1'b0;
                    end
                end
                ST_EXEC: begin
                    res_ff   <= nxt_res;
                    res2_ff  <= nxt_res2;
                    sr_ff    <= nxt_sr;
                    taken_ff <= nxt_taken;
                    cond_ff  <= cnd;
                    trap_ff  <= nxt_trap;
                    priv_ff  <= nxt_priv;
                    stop_ff  <= nxt_stop;
                    if (go_reset) begin
                        rst_cnt_ff <= `RESET_PULSE_CYCLES;
                    end
                    if (go_shift) begin
                        cnt_ff   <= mem ? 6'h01 : cnt_src;
                        xw_ff    <= sr_ff[`SR_X];
                        cw_ff    <= is_rox & sr_ff[`SR_X];
                        vw_ff    <= 1'b0;
                        state_ff <= ST_SHIFT;
                    end else begin
                        state_ff <= ST_IDLE;
                    end
                end
                ST_SHIFT: begin
                    if (cnt_ff != 6'h00) begin
                        res_ff <= shifted;
                        cnt_ff <= cnt_ff - 6'h01;
                        cw_ff  <= out_b;
                        if (!is_rot) begin
                            xw_ff <= out_b;
                        end
                        if (op == `OP_ASL && new_msb != cur_msb) begin
                            vw_ff <= 1'b1; // sign changed somewhere
                        end
                    end else begin
                        sr_ff[`SR_N] <= cur_msb;
                        sr_ff[`SR_Z] <= ~|(res_ff & msk);
                        sr_ff[`SR_V] <= vw_ff;
                        sr_ff[`SR_C] <= cw_ff;
                        sr_ff[`SR_X] <= xw_ff;
                        state_ff     <= ST_IDLE;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end
endmodule

//--- exec_unit_chk.sv
`timescale 1ns/1ps
module exec_unit_chk (
    input wire logic        ref_clk_in,
    input wire logic        rst_b_in,
    input wire logic        ce_in,
    input wire logic        wb_cyc_in,
    input wire logic        wb_stb_in,
    input wire logic        wb_we_in,
    input wire logic [5:0]  wb_adr_in,
    input wire logic [3:0]  wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic        wb_ack_out,
    input wire logic        irq_out,
    input wire logic        ext_reset_out
);
    logic [7:0] xr_cnt_ff;
    // counts advancing edges of the pulse; frozen edges do not count
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) xr_cnt_ff <= 8'h00;
        else if (!ext_reset_out) xr_cnt_ff <= 8'h00;
        else if (ce_in) xr_cnt_ff <= xr_cnt_ff + 8'h01;
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    sequence req_s; wb_cyc_in && wb_stb_in && !wb_ack_out && ce_in; endsequence
    sequence ack_s; wb_ack_out ##1 (!wb_ack_out || !$past(ce_in)); endsequence
    ack_latency_a: assert property (req_s |=> ack_s) else $error("ack late or long");
    ack_cause_a: assert property ($rose(wb_ack_out) |-> $past(wb_cyc_in && wb_stb_in))
        else $error("ack without request");
    ack_idle_a: assert property (ce_in && !(wb_cyc_in && wb_stb_in) |=> !wb_ack_out)
        else $error("ack while idle");
    ack_single_a: assert property (wb_ack_out && ce_in |=> !wb_ack_out) else $error("ack held");
    rdata_hold_a: assert property (!wb_ack_out |-> $stable(wb_dat_out)) else $error("rdata moved");
    ce_freeze_a: assert property (!ce_in |=> $stable(wb_ack_out) && $stable(irq_out)
        && $stable(ext_reset_out)) else $error("outputs moved while frozen");
    xrst_len_a: assert property ($fell(ext_reset_out) |-> xr_cnt_ff == 8'h7B)
        else $error("reset pulse length wrong");
    xrst_min_a: assert property ($rose(ext_reset_out) |-> ext_reset_out[*8])
        else $error("reset pulse cut short");
endmodule
bind exec_unit exec_unit_chk u_chk (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .ce_in(ce_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .irq_out(irq_out),
    .ext_reset_out(ext_reset_out));

//--- seq_model.sv
`timescale 1ns/1ps
module seq_model (
    input  wire logic        clk_in,
    input  wire logic        ack_in,
    input  wire logic [31:0] dat_in,
    output logic             cyc_out,
    output logic             stb_out,
    output logic             we_out,
    output logic [5:0]       adr_out,
    output logic [3:0]       sel_out,
    output logic [31:0]      dat_out
);
    int tmo = 0;
    initial {cyc_out, stb_out, we_out, adr_out, sel_out, dat_out} = '0;
    // whole request held until ack is seen at an edge; a hang only bumps tmo
    task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int n = 0;
        @(posedge clk_in);
        {cyc_out, stb_out, we_out, adr_out, sel_out, dat_out} <= {2'b11, w, a, 4'hF, d};
        do begin
            @(posedge clk_in);
            n++;
        end while (!ack_in && n < 64);
        q = dat_in;
        if (!ack_in) tmo++;
        {cyc_out, stb_out} <= 2'b00;
    endtask
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
`include "exec_unit_defines.vh"
module tb_top;
    logic        ref_clk_in = 1'b0;
    logic        rst_b_in   = 1'b0;
    logic        ce_in      = 1'b1;
    logic        cyc, stb, we, ack, irq, xrst;
    logic [5:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q;
    int          miscompares = 0;
    int          num_checks  = 0;
    initial forever #2.5 ref_clk_in = ~ref_clk_in;
    seq_model u_seq (.clk_in(ref_clk_in), .ack_in(ack), .dat_in(rdat), .cyc_out(cyc),
        .stb_out(stb), .we_out(we), .adr_out(adr), .sel_out(sel), .dat_out(wdat));
    exec_unit u_dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
        .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .irq_out(irq),
        .ext_reset_out(xrst));
    task automatic summarize();
        miscompares += u_seq.tmo;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] t;
        u_seq.xfer(1'b1, a, d, t);
        if (u_seq.tmo != 0) summarize();
    endtask
    task automatic rd(input logic [5:0] a);
        u_seq.xfer(1'b0, a, 32'h0, q);
        if (u_seq.tmo != 0) summarize();
    endtask
    // one op to completion; busy poll has a fixed budget
    task automatic run(input logic [31:0] c, input logic [31:0] a, input logic [31:0] b);
        int n = 0;
        wr(`OFS_OPA, a);
        wr(`OFS_OPB, b);
        wr(`OFS_CTRL, 32'h8000_0000 | c);
        do begin
            rd(`OFS_FLAGS);
            n++;
        end while (q[5] !== 1'b0 && n < 100);
        if (q[5] !== 1'b0) begin
            miscompares++;
            summarize();
        end
        rd(`OFS_RESULT);
    endtask
    initial begin
        repeat (10) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        rd(`OFS_SR);
        chk(q & 32'hFFFF, 32'h2700);
        rd(6'h3C);
        chk(q, 32'h0);
        for (int i = 0; i < 4; i++) begin
            run(i | 32'h40, 32'hF0F0_1234, 32'h0FF0_00FF);
            chk(q, i == 0 ? 32'h00F0_0034 : i == 1 ? 32'hFFF0_12FF :
                   i == 2 ? 32'hFF00_12CB : 32'h0F0F_EDCB);
        end
        $display("logic ops done");
        run(32'h445, 32'h8000_0018, 32'h0);
        chk(q, 32'hF800_0001);
        rd(`OFS_SR);
        chk(q & 32'h11, 32'h11);
        run(32'h40047, 32'h8000_0018, 32'h4);
        chk(q, 32'h0800_0001);
        run(32'hA8, 32'h8001, 32'h0);
        chk(q & 32'hFFFF, 32'h3);
        wr(`OFS_SR, 32'h2710);
        run(32'h10B, 32'h2, 32'h0);
        chk(q & 32'hFF, 32'h81);
        $display("shifts done");
        run(32'h4F, 32'h2, 32'd33);
        chk(q, 32'h0);
        rd(`OFS_SR);
        chk(q & 32'h4, 32'h0);
        run(32'hD, 32'h0, 32'h3);
        chk(q & 32'hFF, 32'h08);
        wr(`OFS_SR, 32'h2710);
        run(32'h10, 32'h45, 32'h38);
        chk(q & 32'hFF, 32'h84);
        run(32'h12, 32'h01, 32'h0);
        chk(q & 32'hFF, 32'h99);
        // only Z set, so the truth table of all sixteen codes is fixed
        for (int i = 0; i < 16; i++) begin
            wr(`OFS_SR, 32'h2704);
            run((i << 14) | 32'h15, 32'h0, 32'h0);
            chk(q & 32'hFF, 16'h9599 >> i & 1 ? 32'hFF : 32'h0);
        end
        wr(`OFS_SR, 32'h2700);
        wr(`OFS_ADDR, 32'h1000);
        run(32'h10013, 32'h0, 32'hFE);
        chk(q, 32'h0FFE);
        run(32'h10033, 32'h0, 32'h8000);
        chk(q, 32'hFFFF_9000);
        run(32'h4014, 32'h1, 32'h10);
        chk(q, 32'h0);
        rd(`OFS_RESULT2);
        chk(q, 32'h1010);
        for (int i = 0; i < 2; i++) begin
            wr(`OFS_SR, 32'h2700 | (i << 1));
            run(32'h401E, 32'h0, 32'h0);
            rd(`OFS_FLAGS);
            chk(q & 32'h4, i << 2);
        end
        $display("conditions done");
        ce_in <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        ce_in <= 1'b1;
        wr(`OFS_IRQ_STAT, 32'h7);
        wr(`OFS_IRQ_MASK, 32'h4);
        wr(`OFS_SR, 32'h0);
        run(32'h1A, 32'h0, 32'h0);
        rd(`OFS_FLAGS);
        chk(q & 32'h8, 32'h8);
        chk({31'h0, xrst}, 32'h0);
        chk({31'h0, irq}, 32'h1);
        wr(`OFS_IRQ_STAT, 32'h4);
        rd(`OFS_IRQ_STAT);
        chk({q[2], irq}, 32'h0);
        wr(`OFS_SR, 32'h2700);
        run(32'h1A, 32'h0, 32'h0);
        repeat (2) @(posedge ref_clk_in);
        chk({31'h0, xrst}, 32'h1);
        repeat (140) @(posedge ref_clk_in);
        chk({31'h0, xrst}, 32'h0);
        $display("privilege done");
        summarize();
    end
endmodule
